// [ccm_defines.vh]
/*
  Constants for the clock mode and oscillation stop detection block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef CCM_DEFINES_VH
`define CCM_DEFINES_VH

// Register indices on the plain register port.
`define CCM_ADDR_MODE      4'h0
`define CCM_ADDR_RDIV      4'h1
`define CCM_ADDR_OSD       4'h2
`define CCM_ADDR_STAT      4'h3

// Clock mode register fields.
`define CCM_MODE_DIV_HI    7
`define CCM_MODE_DIV_LO    6
`define CCM_MODE_OSCSEL    5
`define CCM_MODE_MAIN_STOP 4
`define CCM_MODE_RING_STOP 3
`define CCM_MODE_LOCKMASK  8'h23
`define CCM_MODE_RST       8'h80

// Division ratio codes of bits 7 and 6.
`define CCM_DIV_DOUBLE     2'h3
`define CCM_DIV_HIGH       2'h0
`define CCM_DIV_MIDDLE     2'h1
`define CCM_DIV_RING       2'h2

// Ring division codes.
`define CCM_RDIV_1         2'h0
`define CCM_RDIV_2         2'h1
`define CCM_RDIV_8         2'h2
`define CCM_RDIV_128       2'h3

// Stop detect control fields.
`define CCM_OSD_STATUS     0
`define CCM_OSD_RSTEN      1
`define CCM_OSD_ACTIVE     2

// Stop detection window in ring oscillator edges.
`define CCM_OSD_LIMIT      8'h10

// Stabilization timer load values after halt release.
`define CCM_STAB_TIMER     8'h01
`define CCM_STAB_PRESC     8'hFF

`endif

// [ccm_div.v]
/*
  Programmable divider giving a one-cycle tick every 1, 2, 8 or 128 source
  ticks. Assumes src_tick comes from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module ccm_div
(
  // Clock and reset.
  input  wire       i_sys_clk,
  input  wire       i_rstn,
  // Source and ratio.
  input  wire       i_src_tick,
  input  wire [6:0] i_ratio_m1,
  // Divided tick.
  output wire       o_tick
);

  reg [6:0] cnt_q;

  assign o_tick = i_src_tick && (cnt_q >= i_ratio_m1);

  always @(posedge i_sys_clk)
  begin
    if (!i_rstn)
      cnt_q <= 7'h00;
    else if (i_src_tick)
    begin
      if (cnt_q >= i_ratio_m1)
        cnt_q <= 7'h00;
      else
        cnt_q <= cnt_q + 7'h01;
    end
  end

endmodule
`default_nettype wire

// [ccm_clock_control.v]
/*
  CPU clock selection, wait and halt gating, write-once mode bits and main
  oscillator stop detection. Assumes main and ring oscillator inputs are
  asynchronous levels sampled by the system clock, which is much faster.
*/
// Operation
// RULE1 - Wait instruction holds the CPU clock high, main oscillator keeps running.
// RULE2 - Reset or accepted interrupt restarts the clock gated by wait.
// RULE3 - Software enables wanted interrupts before wait or halt.
// RULE4 - Ring oscillator runs after reset; bit 5 picks ceramic or RC.
// RULE5 - Software uses double-speed only with ceramic oscillation selected.
// RULE6 - Bits 5, 1 and 0 accept one write after reset, then lock.
// RULE7 - Bit set or clear access to other bits also locks bits 5, 1, 0.
// RULE8 - Bits 7-6 divide ratio, bit 4 main stop, bit 3 ring stop.
// RULE9 - Ring mode CPU clock is ring divided by 1, 2, 8 or 128.
// RULE10 - Ring division changes only the CPU clock, not the peripheral clock.
// RULE11 - After reset the CPU clock is ring divided by eight.
// RULE12 - Switching from main to ring forces ring divide by eight.
// RULE13 - Main mode CPU clock is input divided by 2, 8 or undivided.
// RULE14 - Software returns to main clock only after oscillator stabilizes.
// RULE15 - Software inserts 3, 1 or 0 no-ops before stopping main oscillator.
// RULE16 - Active detect bit with ring running monitors the main oscillator.
// RULE17 - A detected main oscillator stop sets the status flag.
// RULE18 - Reset enable bit set makes a detected stop raise internal reset.
// RULE19 - Status flag survives internal stop reset, clears on external reset.
// RULE20 - Writing zero to the active detect bit clears the status flag.
// RULE21 - Active detect bit survives the internal stop reset.
// RULE22 - Software never halts while stop detection is active.
// RULE23 - Halt wake holds clock high until timer 01 with prescaler FF underflows.
// RULE24 - Stop declared when no main edge appears within a fixed ring count.
`timescale 1ns/100ps
`default_nettype none
`include "ccm_defines.vh"
module ccm_clock_control
(
  // Clock and external reset.
  input  wire       i_sys_clk,
  input  wire       i_rstn,
  // Register port.
  input  wire [3:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  input  wire       i_rmw,
  output reg  [7:0] o_rdata,
  // Oscillator inputs.
  input  wire       i_main_osc,
  input  wire       i_ring_osc,
  // CPU events.
  input  wire       i_wait_instruction,
  input  wire       i_halt_oscillator_instruction,
  input  wire       i_irq_accept,
  input  wire       i_stab_long,
  // Clock outputs.
  output reg        o_cpu_clk,
  output reg        o_periph_clk,
  output wire       o_main_osc_en,
  output wire       o_ring_osc_en,
  output reg        o_int_reset
);

  localparam ST_RUN  = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_HALT = 2'h2;
  localparam ST_STAB = 2'h3;

  //////////////////////////////////////////////////////////////////////////

  reg        m_s1_q, m_s2_q, m_s3_q;
  reg        r_s1_q, r_s2_q, r_s3_q;
  reg  [7:0] mode_q;
  reg        locked_q;
  reg  [1:0] rdiv_q;
  reg        osd_act_q;
  reg        osd_rsten_q;
  reg        osd_stat_q;
  reg  [7:0] osd_cnt_q;
  reg  [1:0] state_q;
  reg  [7:0] presc_q;
  reg  [7:0] timer_q;
  reg        int_rst_q;
  wire       soft_rstn;
  wire       main_edge;
  wire       ring_tick;
  wire       main_tick;
  wire       use_ring;
  wire       cpu_tick;
  wire       ring_cpu_tick;
  wire       main_cpu_tick;
  wire       wr_mode;
  wire       wr_osd;
  wire       gate;
  wire       osd_fire;
  wire [1:0] div_sel;

  function [6:0] ratio_m1;
    input [1:0] code;
    begin
      case (code)
        `CCM_RDIV_1:   ratio_m1 = 7'h00;
        `CCM_RDIV_2:   ratio_m1 = 7'h01;
        `CCM_RDIV_8:   ratio_m1 = 7'h07;
        default:       ratio_m1 = 7'h7F;
      endcase
    end
  endfunction

  function [1:0] main_code;
    input [1:0] div;
    begin
      if (div == `CCM_DIV_DOUBLE)
        main_code = `CCM_RDIV_1;
      else if (div == `CCM_DIV_HIGH)
        main_code = `CCM_RDIV_2;
      else
        main_code = `CCM_RDIV_8;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Synchronisers and edge detection of both oscillators.

  always @(posedge i_sys_clk)
  begin
    if (!i_rstn)
    begin
      m_s1_q <= 1'b0;
      m_s2_q <= 1'b0;
      m_s3_q <= 1'b0;
      r_s1_q <= 1'b0;
      r_s2_q <= 1'b0;
      r_s3_q <= 1'b0;
    end
    else
    begin
      m_s1_q <= i_main_osc;
      m_s2_q <= m_s1_q;
      m_s3_q <= m_s2_q;
      r_s1_q <= i_ring_osc;
      r_s2_q <= r_s1_q;
      r_s3_q <= r_s2_q;
    end
  end

  // Both source edges tick, so a ratio of N gives the source divided by N.
  assign main_edge = (m_s2_q ^ m_s3_q) && o_main_osc_en;
  assign main_tick = main_edge;
  assign ring_tick = (r_s2_q ^ r_s3_q) && o_ring_osc_en;

  //////////////////////////////////////////////////////////////////////////
  // Register writes, write-once lock and ring divider.

  assign soft_rstn = i_rstn && !int_rst_q;
  assign wr_mode   = i_wr && (i_addr == `CCM_ADDR_MODE);
  assign wr_osd    = i_wr && (i_addr == `CCM_ADDR_OSD);
  assign div_sel   = mode_q[`CCM_MODE_DIV_HI:`CCM_MODE_DIV_LO];
  assign use_ring  = (div_sel == `CCM_DIV_RING); // RULE4

  always @(posedge i_sys_clk)
  begin
    if (!soft_rstn)
    begin
      mode_q   <= `CCM_MODE_RST; // RULE4
      locked_q <= 1'b0;
      rdiv_q   <= `CCM_RDIV_8; // RULE11
    end
    else
    begin
      if (wr_mode)
      begin
        if (locked_q)
          mode_q <= (i_wdata & ~`CCM_MODE_LOCKMASK) |
                    (mode_q & `CCM_MODE_LOCKMASK); // RULE6
        else
          mode_q <= i_wdata; // RULE8
        locked_q <= 1'b1; // RULE6
        if (i_rmw)
          locked_q <= 1'b1; // RULE7
        if ((i_wdata[7:6] == `CCM_DIV_RING) && !use_ring)
          rdiv_q <= `CCM_RDIV_8; // RULE12
      end
      else if (i_wr && (i_addr == `CCM_ADDR_RDIV))
        rdiv_q <= i_wdata[1:0]; // RULE9
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Stop detection; control bits survive the internal reset.

  assign osd_fire = osd_act_q && ring_tick && !main_edge &&
                    (osd_cnt_q == `CCM_OSD_LIMIT - 8'h01); // RULE24

  always @(posedge i_sys_clk)
  begin
    if (!i_rstn)
    begin
      osd_act_q   <= 1'b0;
      osd_rsten_q <= 1'b0;
      osd_stat_q  <= 1'b0; // RULE19
      osd_cnt_q   <= 8'h00;
      int_rst_q   <= 1'b0;
      o_int_reset <= 1'b0;
    end
    else
    begin
      int_rst_q   <= osd_fire && osd_rsten_q && !int_rst_q; // RULE18
      o_int_reset <= int_rst_q;
      if (!osd_act_q || main_edge)
        osd_cnt_q <= 8'h00;
      else if (ring_tick && (osd_cnt_q != `CCM_OSD_LIMIT))
        osd_cnt_q <= osd_cnt_q + 8'h01; // RULE16
      if (wr_osd)
      begin
        osd_act_q   <= i_wdata[`CCM_OSD_ACTIVE]; // RULE21
        osd_rsten_q <= i_wdata[`CCM_OSD_RSTEN];
      end
      if (osd_fire)
        osd_stat_q <= 1'b1; // RULE17
      else if (wr_osd && !i_wdata[`CCM_OSD_ACTIVE])
        osd_stat_q <= 1'b0; // RULE20
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // CPU clock dividers; peripheral clock ignores the ring ratio.

  ccm_div u_ring_div
  (
    .i_sys_clk  (i_sys_clk),
    .i_rstn     (soft_rstn),
    .i_src_tick (ring_tick),
    .i_ratio_m1 (ratio_m1(rdiv_q)),
    .o_tick     (ring_cpu_tick)
  );

  ccm_div u_main_div
  (
    .i_sys_clk  (i_sys_clk),
    .i_rstn     (soft_rstn),
    .i_src_tick (main_tick),
    .i_ratio_m1 (ratio_m1(main_code(div_sel))),
    .o_tick     (main_cpu_tick)
  );

  assign cpu_tick = use_ring ? ring_cpu_tick : main_cpu_tick; // RULE13

  //////////////////////////////////////////////////////////////////////////
  // Wait and halt sequencing.

  always @(posedge i_sys_clk)
  begin
    if (!soft_rstn)
    begin
      state_q <= ST_RUN; // RULE2
      presc_q <= 8'h00;
      timer_q <= 8'h00;
    end
    else
    begin
      case (state_q)
        ST_RUN:
        begin
          if (i_halt_oscillator_instruction)
          begin
            state_q <= ST_HALT;
            if (!i_stab_long)
            begin
              timer_q <= `CCM_STAB_TIMER; // RULE23
              presc_q <= `CCM_STAB_PRESC;
            end
          end
          else if (i_wait_instruction)
            state_q <= ST_WAIT; // RULE1
        end
        ST_WAIT:
        begin
          if (i_irq_accept)
            state_q <= ST_RUN; // RULE2
        end
        ST_HALT:
        begin
          if (i_irq_accept)
            state_q <= ST_STAB;
        end
        default:
        begin
          if (main_tick)
          begin
            if (presc_q != 8'h00)
              presc_q <= presc_q - 8'h01;
            else if (timer_q != 8'h00)
            begin
              presc_q <= `CCM_STAB_PRESC;
              timer_q <= timer_q - 8'h01;
            end
            else
              state_q <= ST_RUN; // RULE23
          end
        end
      endcase
    end
  end

  assign gate = (state_q != ST_RUN);
  assign o_main_osc_en = !mode_q[`CCM_MODE_MAIN_STOP] &&
                         (state_q != ST_HALT); // RULE1
  assign o_ring_osc_en = !mode_q[`CCM_MODE_RING_STOP]; // RULE8

  always @(posedge i_sys_clk)
  begin
    if (!soft_rstn)
    begin
      o_cpu_clk    <= 1'b1;
      o_periph_clk <= 1'b1;
    end
    else
    begin
      if (gate)
        o_cpu_clk <= 1'b1; // RULE1
      else if (cpu_tick)
        o_cpu_clk <= !o_cpu_clk;
      if (use_ring ? ring_tick : main_tick)
        o_periph_clk <= !o_periph_clk; // RULE10
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe.

  always @(posedge i_sys_clk)
  begin
    if (!i_rstn)
      o_rdata <= 8'h00;
    else if (i_rd)
    begin
      if (i_addr == `CCM_ADDR_MODE)
        o_rdata <= mode_q;
      else if (i_addr == `CCM_ADDR_RDIV)
        o_rdata <= {6'h00, rdiv_q};
      else if (i_addr == `CCM_ADDR_OSD)
        o_rdata <= {5'h00, osd_act_q, osd_rsten_q, osd_stat_q};
      else if (i_addr == `CCM_ADDR_STAT)
        o_rdata <= {4'h0, locked_q, use_ring, state_q};
      else
        o_rdata <= 8'h00;
    end
    else
      o_rdata <= 8'h00;
  end

endmodule
`default_nettype wire

// [ccm_osc_model.sv]
/* Main oscillator model.
   Assumes the bench clock and the oscillator enable of the block. */
`timescale 1ns/100ps
`default_nettype none
module ccm_osc_model
#(parameter int HALF = 4)
(
  // Clock and control.
  input  wire logic i_sys_clk,
  input  wire logic i_run,
  input  wire logic i_en,
  // Oscillator level.
  output var  logic o_osc
);
  int cnt = 0;
  initial o_osc = 1'b0;
  // It swings only while enabled and not broken.
  always @(posedge i_sys_clk)
  begin
    if (i_run && i_en)
    begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1)
        o_osc <= ~o_osc;
    end
  end
endmodule
`default_nettype wire

// [ccm_sva.sv]
/* Port checker for the clock control block.
   Assumes a bind to the block with the port names used here. */
`timescale 1ns/100ps
`default_nettype none
module ccm_sva
(
  // Clock, reset and register port.
  input wire logic       i_sys_clk,
  input wire logic       i_rstn,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  // Events and clock outputs.
  input wire logic       i_wait_instruction,
  input wire logic       i_halt_oscillator_instruction,
  input wire logic       i_irq_accept,
  input wire logic       i_stab_long,
  input wire logic       o_cpu_clk,
  input wire logic       o_main_osc_en,
  input wire logic       o_ring_osc_en,
  input wire logic       o_int_reset
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  a_wait_gate:
    assert property (i_wait_instruction ##1 !i_irq_accept [*4] |-> o_cpu_clk)
    else $error("cpu clock not held in wait");
  a_ring_ctl:
    assert property (i_wr && i_addr == 4'h0
      |=> o_ring_osc_en == !$past(i_wdata[3]))
    else $error("ring enable wrong");
  a_main_ctl:
    assert property (i_wr && i_addr == 4'h0 && i_wdata[4] |=> !o_main_osc_en)
    else $error("main enable wrong");
  a_halt_osc:
    assert property (i_halt_oscillator_instruction |=> !o_main_osc_en)
    else $error("main runs in halt");
  a_halt_hold:
    assert property (i_halt_oscillator_instruction && !i_stab_long
      |-> ##2 o_cpu_clk [*8])
    else $error("cpu clock not held in halt");
  a_stop_quiet:
    assert property (i_wr && i_addr == 4'h2 && !i_wdata[1]
      ##1 !(i_wr && i_addr == 4'h2) [*4] |-> !o_int_reset)
    else $error("reset while disabled");
  a_rst_pulse:
    assert property (o_int_reset |=> !o_int_reset)
    else $error("internal reset too long");
  a_int_ring:
    assert property (o_int_reset |-> ##2 o_ring_osc_en)
    else $error("ring off after reset");
  a_rd_slot:
    assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside slot");
endmodule
bind ccm_clock_control ccm_sva chk_u (.i_sys_clk, .i_rstn, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .i_wait_instruction,
  .i_halt_oscillator_instruction, .i_irq_accept, .i_stab_long, .o_cpu_clk,
  .o_main_osc_en, .o_ring_osc_en, .o_int_reset);
`default_nettype wire

// [ccm_clock_control_tb_top.sv]
/* Bench for the clock control block.
   Assumes the bound checker and the oscillator model. */
`timescale 1ns/100ps
`default_nettype none
module ccm_clock_control_tb_top;
  logic       i_sys_clk = 0, i_rstn = 0, i_wr = 0, i_rd = 0, i_rmw = 0;
  logic [3:0] i_addr = 0;
  logic [7:0] i_wdata = 0, o_rdata;
  logic       i_ring_osc = 0, i_wait_instruction = 0, i_irq_accept = 0;
  logic       i_halt_oscillator_instruction = 0, i_stab_long = 0, run = 1;
  logic       i_main_osc, o_cpu_clk, o_periph_clk, o_main_osc_en;
  logic       o_ring_osc_en, o_int_reset;
  int         err_count = 0, total_checks = 0, cc, pc, mc, ir, rc, i, r, p0;
  int         seed = 32'h91FA94F6;
  int         mdl_mode = 'h80, mdl_lock = 0, mdl_rdiv = 2;
  always #5 i_sys_clk = ~i_sys_clk;
  always @(posedge o_cpu_clk) cc++;
  always @(posedge o_periph_clk) pc++;
  always @(posedge i_main_osc) mc++;
  always @(posedge o_int_reset) ir++;
  always @(posedge i_sys_clk)
  begin
    rc <= (rc == 2) ? 0 : rc + 1;
    if (rc == 2 && o_ring_osc_en)
      i_ring_osc <= ~i_ring_osc;
  end
  ccm_osc_model osc_u (.i_sys_clk, .i_run(run), .i_en(o_main_osc_en),
    .o_osc(i_main_osc));
  ccm_clock_control dut_u (.i_sys_clk, .i_rstn, .i_addr, .i_wdata, .i_wr,
    .i_rd, .i_rmw, .o_rdata, .i_main_osc, .i_ring_osc, .i_wait_instruction,
    .i_halt_oscillator_instruction, .i_irq_accept, .i_stab_long, .o_cpu_clk,
    .o_periph_clk, .o_main_osc_en, .o_ring_osc_en, .o_int_reset);
  ////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic mrst;
    mdl_mode = 'h80;
    mdl_lock = 0;
    mdl_rdiv = 2;
  endtask
  task automatic rst;
    i_rstn <= 1'b0;
    mrst;
    repeat (8) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
  endtask
  task automatic wrr(input logic [3:0] a, input logic [7:0] d, input bit m);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_rmw <= m;
    i_wr <= 1'b1;
    if (a == 4'h0 && d[7:6] == 2'h2 && mdl_mode[7:6] != 2'h2)
      mdl_rdiv = 2;
    if (a == 4'h1)
      mdl_rdiv = d[1:0];
    if (a == 4'h0)
      mdl_mode = mdl_lock ? (d & 8'hDC) | (mdl_mode[7:0] & 8'h23) : d;
    if (a == 4'h0)
      mdl_lock = 1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    i_rmw <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
    if (a == 4'h0)
      chk(o_rdata, mdl_mode[7:0]);
    if (a == 4'h1)
      chk(o_rdata, mdl_rdiv[7:0]);
  endtask
  task automatic meas(input int q, input bit src);
    cc = 0;
    pc = 0;
    mc = 0;
    repeat (3000) @(posedge i_sys_clk);
    i = src ? mc : pc;
    chk({7'h00, cc * q + q + 1 >= i && i + q + 1 >= cc * q}, 8'h01);
  endtask
  task automatic wcpu(input int n);
    cc = 0;
    for (i = 0; i < n && cc == 0; i++)
      @(posedge i_sys_clk);
    chk({7'h00, cc != 0}, 8'h01);
    if (cc == 0)
      results;
  endtask
  task automatic pulse(input int w);
    @(posedge i_sys_clk);
    if (w == 0) i_wait_instruction <= 1'b1;
    if (w == 1) i_halt_oscillator_instruction <= 1'b1;
    if (w == 2) i_irq_accept <= 1'b1;
    @(posedge i_sys_clk);
    i_wait_instruction <= 1'b0;
    i_halt_oscillator_instruction <= 1'b0;
    i_irq_accept <= 1'b0;
  endtask
  initial
  begin
    repeat (100000) @(posedge i_sys_clk);
    err_count++;
    results;
  end
  initial
  begin
    rst;
    rdc(4'h0, 8'h80);
    rdc(4'h1, 8'h02);
    rdc(4'h2, 8'h00);
    chk({7'h00, o_ring_osc_en}, 8'h01);
    wrr(4'h0, 8'hA3, 0);
    r = $random(seed);
    wrr(4'h0, 8'h80 | (r[7:0] & 8'h33), 0);
    rdc(4'h0, 8'hA3 | (r[7:0] & 8'h10));
    for (int k = 0; k < 4; k++)
    begin
      wrr(4'h1, k[7:0], 0);
      meas(k == 3 ? 128 : k == 2 ? 8 : k + 1, 0);
      if (k == 0) p0 = pc;
      chk({7'h00, pc + 2 >= p0 && p0 + 2 >= pc}, 8'h01);
    end
    rst;
    wrr(4'h0, 8'h90, 1);
    wrr(4'h0, 8'hC3, 0);
    rdc(4'h0, 8'hC0);
    rst;
    repeat (50) @(posedge i_sys_clk);
    wrr(4'h0, 8'h00, 0);
    meas(2, 1);
    wrr(4'h0, 8'h40, 0);
    meas(8, 1);
    wrr(4'h0, 8'hC0, 0);
    meas(1, 1);
    wrr(4'h1, 8'h00, 0);
    wrr(4'h0, 8'h80, 0);
    rdc(4'h1, 8'h02);
    pulse(0);
    repeat (20) @(posedge i_sys_clk);
    cc = 0;
    repeat (20) @(posedge i_sys_clk);
    chk({6'h00, o_main_osc_en, cc != 0}, 8'h02);
    pulse(2);
    wcpu(300);
    pulse(1);
    repeat (20) @(posedge i_sys_clk);
    pulse(2);
    cc = 0;
    repeat (100) @(posedge i_sys_clk);
    chk({7'h00, cc != 0}, 8'h00);
    wcpu(20000);
    i_stab_long <= 1'b1;
    pulse(1);
    pulse(2);
    wcpu(300);
    i_stab_long <= 1'b0;
    wrr(4'h2, 8'h04, 0);
    run <= 1'b0;
    repeat (200) @(posedge i_sys_clk);
    rdc(4'h2, 8'h05);
    chk(ir[7:0], 8'h00);
    wrr(4'h2, 8'h00, 0);
    rdc(4'h2, 8'h00);
    wrr(4'h2, 8'h06, 0);
    for (i = 0; i < 400 && ir == 0; i++)
      @(posedge i_sys_clk);
    run <= 1'b1;
    mrst;
    chk(ir[7:0], 8'h01);
    repeat (10) @(posedge i_sys_clk);
    rdc(4'h2, 8'h07);
    rdc(4'h0, 8'h80);
    rst;
    rdc(4'h2, 8'h00);
    results;
  end
endmodule
`default_nettype wire
